// *** verilog/arc_pkg.sv ***
/*
 Constants, layouts and types for the converter reference, ground and
 temperature sensor control block.
 Assumes a byte-wide special function register port on core_clk.
*/
// Contract
// - The sensor is powered only while the sensor enable bit is set.
// - A disabled sensor leaves its output in high impedance, so readings from it are meaningless.
// - Select 11 uses the 1.65 V fast reference, powered only while the converter needs it.
// - Precision enable 1 with select 00 powers the 1.68 V precision reference and uses it.
// - Select 01 uses the main supply and select 10 the regulated digital supply.
// - Ground select 1 takes converter ground from the dedicated ground pin in tracking and conversion.
// - While the sensor is sampled the internal ground is used, whatever the ground select.
// - While the fast reference is selected the internal ground is used during conversion.
// - The offset high register reads offset bits 9:2 and is read-only.
// - The offset low register reads offset bits 1:0 in 7:6 and zero in 5:0, ignoring writes.
// - The offset registers hold a per-part production measurement, so their reset value varies.
// - Control register layout: ground select 5, reference select 4:3, sensor enable 2, precision enable 0.
package arc_pkg;
    localparam logic [7:0] ARC_ADDR_REFCTL = 8'hd1;
    localparam logic [7:0] ARC_ADDR_OFFL = 8'h85;
    localparam logic [7:0] ARC_ADDR_OFFH = 8'h86;
    localparam int ARC_BIT_GND = 5;
    localparam int ARC_BIT_SEL_HI = 4;
    localparam int ARC_BIT_SEL_LO = 3;
    localparam int ARC_BIT_TEMP = 2;
    localparam int ARC_BIT_PREC = 0;
    localparam logic [7:0] ARC_REFCTL_RST = 8'h18;
    localparam logic [7:0] ARC_REFCTL_WMASK = 8'h3d;
    localparam int ARC_OFF_W = 10;

    typedef enum logic [1:0] {
        ARC_SEL_EXT = 2'h0,
        ARC_SEL_VDD = 2'h1,
        ARC_SEL_VREG = 2'h2,
        ARC_SEL_FAST = 2'h3
    } arc_sel_e;

    // One-hot reference source seen by the converter
    typedef enum logic [4:0] {
        ARC_SRC_PIN = 5'h01,
        ARC_SRC_PREC = 5'h02,
        ARC_SRC_VDD = 5'h04,
        ARC_SRC_VREG = 5'h08,
        ARC_SRC_FAST = 5'h10
    } arc_src_e;

    typedef struct packed {
        logic gnd_sel;
        arc_sel_e ref_sel;
        logic temp_en;
        logic prec_en;
    } arc_state_s;

    typedef struct packed {
        logic tracking;
        logic converting;
        logic sensor_chan;
    } arc_conv_s;

    typedef struct packed {
        arc_src_e ref_src;
        logic prec_ref_on;
        logic fast_ref_on;
        logic sensor_power;
        logic sensor_out_oe;
        logic gnd_from_pin;
        logic prec_to_pin;
    } arc_ana_s;
endpackage

// *** verilog/arc_ctrl.sv ***
/*
 Reference, ground and temperature sensor control: register port and
 analog control decode.
 Assumes a single-cycle register port from the core and converter phase
 levels synchronous to core_clk.
*/
`timescale 1ns/1ps
module arc_ctrl #(
    parameter logic [9:0] FACTORY_OFFSET = 10'h000
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire arc_pkg::arc_conv_s conv,
    output arc_pkg::arc_ana_s ana
);
    import arc_pkg::*;

    typedef struct packed {
        arc_state_s ctl;
        logic [7:0] rdata;
    } arc_regs_s;

    // Reset image built field by field from the documented reset byte
    localparam arc_regs_s ARC_REGS_RST = '{
        ctl: '{gnd_sel: ARC_REFCTL_RST[ARC_BIT_GND],
            ref_sel: arc_sel_e'(ARC_REFCTL_RST[ARC_BIT_SEL_HI:ARC_BIT_SEL_LO]),
            temp_en: ARC_REFCTL_RST[ARC_BIT_TEMP],
            prec_en: ARC_REFCTL_RST[ARC_BIT_PREC]},
        rdata: 8'h00
    };

    arc_regs_s q, next_q;
    arc_state_s st;
    logic [7:0] refctl_rd;

    assign st = q.ctl;
    assign sfr_rdata = q.rdata;
    assign refctl_rd = {2'h0, st.gnd_sel, st.ref_sel, st.temp_en, 1'b0, st.prec_en} & ARC_REFCTL_WMASK;

    always_comb begin
        next_q = q;
        if (sfr_wr && sfr_addr == ARC_ADDR_REFCTL) begin
            next_q.ctl.gnd_sel = sfr_wdata[ARC_BIT_GND];
            next_q.ctl.ref_sel = arc_sel_e'(sfr_wdata[ARC_BIT_SEL_HI:ARC_BIT_SEL_LO]);
            next_q.ctl.temp_en = sfr_wdata[ARC_BIT_TEMP];
            next_q.ctl.prec_en = sfr_wdata[ARC_BIT_PREC];
        end
        // Writes to the offset registers change nothing
        // Read uses the old control value, so a same-cycle write is not seen yet
        if (sfr_rd) begin
            case (sfr_addr)
                ARC_ADDR_REFCTL: next_q.rdata = refctl_rd;
                ARC_ADDR_OFFH: next_q.rdata = FACTORY_OFFSET[9:2];
                ARC_ADDR_OFFL: next_q.rdata = {FACTORY_OFFSET[1:0], 6'h00};
                default: next_q.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            q <= ARC_REGS_RST;
        end else begin
            q <= next_q;
        end
    end

    always_comb begin
        ana = '0;
        case (st.ref_sel)
            ARC_SEL_EXT: ana.ref_src = st.prec_en ? ARC_SRC_PREC : ARC_SRC_PIN;
            ARC_SEL_VDD: ana.ref_src = ARC_SRC_VDD;
            ARC_SEL_VREG: ana.ref_src = ARC_SRC_VREG;
            ARC_SEL_FAST: ana.ref_src = ARC_SRC_FAST;
            default: ana.ref_src = ARC_SRC_PIN;
        endcase
        // Precision reference drives the reference pin whenever enabled
        ana.prec_ref_on = st.prec_en;
        ana.prec_to_pin = st.prec_en;
        // Fast reference stays asleep between conversions to save power
        ana.fast_ref_on = (st.ref_sel == ARC_SEL_FAST) && (conv.tracking || conv.converting);
        ana.sensor_power = st.temp_en;
        ana.sensor_out_oe = st.temp_en;
        ana.gnd_from_pin = st.gnd_sel && (conv.tracking || conv.converting)
            && !(conv.tracking && conv.sensor_chan)
            && !(conv.converting && st.ref_sel == ARC_SEL_FAST);
    end

    chk_sensor_power: assert property (@(posedge core_clk) disable iff (!rstn)
        ana.sensor_power == st.temp_en && ana.sensor_out_oe == st.temp_en)
        else $error("sensor power does not follow enable");
    chk_sensor_float: assert property (@(posedge core_clk) disable iff (!rstn)
        !st.temp_en |-> !ana.sensor_out_oe)
        else $error("sensor output driven while disabled");
    chk_write_apply: assert property (@(posedge core_clk) disable iff (!rstn)
        sfr_wr && sfr_addr == ARC_ADDR_REFCTL |=> st.temp_en == $past(sfr_wdata[2])
            && st.ref_sel == $past(sfr_wdata[4:3]) && st.gnd_sel == $past(sfr_wdata[5])
            && st.prec_en == $past(sfr_wdata[0]))
        else $error("control write not applied next edge");
    chk_write_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        !(sfr_wr && sfr_addr == ARC_ADDR_REFCTL) |=> $stable(st))
        else $error("control changed without a write");
    chk_fast_ground: assert property (@(posedge core_clk) disable iff (!rstn)
        conv.converting && st.ref_sel == ARC_SEL_FAST |-> !ana.gnd_from_pin)
        else $error("pin ground used with fast reference");
    chk_sensor_ground: assert property (@(posedge core_clk) disable iff (!rstn)
        conv.tracking && conv.sensor_chan |-> !ana.gnd_from_pin)
        else $error("pin ground used while sampling sensor");
    chk_pin_ground: assert property (@(posedge core_clk) disable iff (!rstn)
        st.gnd_sel && conv.tracking && !conv.sensor_chan && !conv.converting |-> ana.gnd_from_pin)
        else $error("pin ground not used");
    chk_ground_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        !st.gnd_sel |-> !ana.gnd_from_pin)
        else $error("pin ground used while not selected");
    chk_prec_select: assert property (@(posedge core_clk) disable iff (!rstn)
        st.prec_en && st.ref_sel == ARC_SEL_EXT |-> ana.ref_src == ARC_SRC_PREC && ana.prec_ref_on)
        else $error("precision reference not used");
    chk_prec_off: assert property (@(posedge core_clk) disable iff (!rstn)
        !st.prec_en |-> !ana.prec_ref_on && !ana.prec_to_pin)
        else $error("precision reference on while disabled");
    chk_pin_select: assert property (@(posedge core_clk) disable iff (!rstn)
        !st.prec_en && st.ref_sel == ARC_SEL_EXT |-> ana.ref_src == ARC_SRC_PIN)
        else $error("external reference pin not used");
    chk_supply_select: assert property (@(posedge core_clk) disable iff (!rstn)
        st.ref_sel == ARC_SEL_VREG |-> ana.ref_src == ARC_SRC_VREG)
        else $error("digital supply not used");
    chk_main_select: assert property (@(posedge core_clk) disable iff (!rstn)
        st.ref_sel == ARC_SEL_VDD |-> ana.ref_src == ARC_SRC_VDD)
        else $error("main supply not used");
    chk_fast_select: assert property (@(posedge core_clk) disable iff (!rstn)
        st.ref_sel == ARC_SEL_FAST |-> ana.ref_src == ARC_SRC_FAST)
        else $error("fast reference not used");
    chk_fast_idle: assert property (@(posedge core_clk) disable iff (!rstn)
        !conv.tracking && !conv.converting |-> !ana.fast_ref_on)
        else $error("fast reference on while idle");
    chk_fast_active: assert property (@(posedge core_clk) disable iff (!rstn)
        st.ref_sel == ARC_SEL_FAST && (conv.tracking || conv.converting) |-> ana.fast_ref_on)
        else $error("fast reference off while needed");
    chk_offset_high: assert property (@(posedge core_clk) disable iff (!rstn)
        sfr_rd && sfr_addr == ARC_ADDR_OFFH |=> sfr_rdata == FACTORY_OFFSET[9:2])
        else $error("offset high read wrong");
    chk_offset_low: assert property (@(posedge core_clk) disable iff (!rstn)
        sfr_rd && sfr_addr == ARC_ADDR_OFFL |=> sfr_rdata[5:0] == 6'h00)
        else $error("offset low unused bits not zero");
    chk_offset_bits: assert property (@(posedge core_clk) disable iff (!rstn)
        sfr_rd && sfr_addr == ARC_ADDR_OFFL |=> sfr_rdata[7:6] == FACTORY_OFFSET[1:0])
        else $error("offset low bits wrong");
    chk_ctl_unused: assert property (@(posedge core_clk) disable iff (!rstn)
        sfr_rd && sfr_addr == ARC_ADDR_REFCTL |=> sfr_rdata[7:6] == 2'h0 && !sfr_rdata[1])
        else $error("control unused bits not zero");
    chk_rdata_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        !sfr_rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");
endmodule

// *** test/arc_ctrl_tb.sv ***
/*
 Self-checking bench for the reference, ground and sensor control block.
 Assumes the register port and phase inputs are driven on the falling edge.
*/
`timescale 1ns/1ps
module testbench;
    import arc_pkg::*;
    localparam logic [9:0] OFFSET = 10'h2b7;
    typedef struct packed { logic [7:0] rd; arc_ana_s an; } arc_note_s;
    logic core_clk = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d;
    logic [7:0] ctl = ARC_REFCTL_RST, exp_rd = 8'h00;
    arc_conv_s conv = '0;
    arc_conv_s conv_pick = '0;
    logic pick = 1'b0;
    arc_ana_s ana;
    arc_note_s notes[$];
    arc_note_s got;
    int miscompares = 0, num_checks = 0;
    event ev_res;
    always #5 core_clk = ~core_clk;
    arc_ctrl #(.FACTORY_OFFSET(OFFSET)) i_dut (.core_clk(core_clk), .rstn(rstn), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .conv(conv), .ana(ana));
    function automatic arc_ana_s model(input logic [7:0] c, input arc_conv_s v);
        arc_ana_s a;
        logic act;
        act = v.tracking | v.converting;
        case (c[4:3])
            2'h0: a.ref_src = c[0] ? ARC_SRC_PREC : ARC_SRC_PIN;
            2'h1: a.ref_src = ARC_SRC_VDD;
            2'h2: a.ref_src = ARC_SRC_VREG;
            default: a.ref_src = ARC_SRC_FAST;
        endcase
        a.prec_ref_on = c[0];
        a.fast_ref_on = (c[4:3] == 2'h3) & act;
        a.sensor_power = c[2];
        a.sensor_out_oe = c[2];
        // Pin ground only in active phases, and never where the internal ground is forced
        a.gnd_from_pin = c[5] & act & ~(v.sensor_chan & v.tracking) & ~((c[4:3] == 2'h3) & v.converting);
        a.prec_to_pin = c[0];
        return a;
    endfunction
    task automatic op(input logic w, input logic r, input logic [7:0] ad, input logic [7:0] dat);
        @(negedge core_clk);
        sfr_wr = w;
        sfr_rd = r;
        sfr_addr = ad;
        sfr_wdata = dat;
        conv = pick ? conv_pick : arc_conv_s'(3'($urandom));
        // Read is resolved before the write lands, so a same-cycle read sees the old value
        if (r) begin
            exp_rd = (ad == ARC_ADDR_REFCTL) ? ctl : (ad == ARC_ADDR_OFFH) ? OFFSET[9:2] :
                (ad == ARC_ADDR_OFFL) ? {OFFSET[1:0], 6'h00} : 8'h00;
        end
        if (w && ad == ARC_ADDR_REFCTL) begin
            ctl = dat & ARC_REFCTL_WMASK;
        end
        notes.push_back({exp_rd, model(ctl, conv)});
        @(negedge core_clk);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        ->ev_res;
    endtask
    task automatic close_out;
        @(negedge core_clk);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial forever begin
        @(ev_res);
        got = notes.pop_front();
        num_checks++;
        if (sfr_rdata !== got.rd) begin
            miscompares++;
            $display("unexpected sfr_rdata expected %h seen %h", got.rd, sfr_rdata);
        end
        num_checks++;
        if (ana !== got.an) begin
            miscompares++;
            $display("unexpected ana expected %h seen %h", got.an, ana);
        end
    end
    initial begin
        #20000;
        miscompares++;
        close_out;
    end
    initial begin
        void'($urandom(32'h959e));
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        rstn = 1'b1;
        op(1'b0, 1'b1, ARC_ADDR_REFCTL, 8'h00);
        op(1'b0, 1'b1, ARC_ADDR_OFFH, 8'h00);
        op(1'b1, 1'b1, ARC_ADDR_OFFL, 8'hff);
        op(1'b1, 1'b0, ARC_ADDR_OFFH, 8'h00);
        op(1'b0, 1'b1, ARC_ADDR_OFFL, 8'h00);
        op(1'b0, 1'b1, ARC_ADDR_OFFH, 8'h00);
        op(1'b0, 1'b1, 8'h42, 8'h00);
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < 8; k++) begin
                d = 8'($urandom);
                d[4:3] = 2'(s);
                op(1'b1, 1'b0, ARC_ADDR_REFCTL, d);
                op(1'b0, 1'b1, ARC_ADDR_REFCTL, 8'h00);
            end
        end
        pick = 1'b1;
        op(1'b1, 1'b0, ARC_ADDR_REFCTL, 8'h00);
        op(1'b1, 1'b1, ARC_ADDR_REFCTL, 8'h01);
        conv_pick = '{tracking: 1'b1, converting: 1'b0, sensor_chan: 1'b0};
        op(1'b1, 1'b0, ARC_ADDR_REFCTL, 8'h24);
        conv_pick = '{tracking: 1'b1, converting: 1'b0, sensor_chan: 1'b1};
        op(1'b0, 1'b1, ARC_ADDR_REFCTL, 8'h00);
        conv_pick = '{tracking: 1'b0, converting: 1'b1, sensor_chan: 1'b1};
        op(1'b1, 1'b0, ARC_ADDR_REFCTL, 8'h3c);
        pick = 1'b0;
        close_out;
    end
endmodule
